// ===== rtl/tsrc_map.svh
// tsrc_map.svh: timing counts and default selector positions for the transfer switch
// reset and option control; assumes a 10 MHz system clock.
`ifndef TSRC_MAP_SVH
`define TSRC_MAP_SVH
`define TSRC_CLK_HZ 10000000
`define TSRC_TICK_CYC (`TSRC_CLK_HZ)
`define TSRC_CLEAR_HOLD_S 3
`define TSRC_RESET_HOLD_S 6
`define TSRC_TEST_PRESS_S 1
`define TSRC_DEBOUNCE_CYC 16
`define TSRC_SEC_PER_MIN 60
`define TSRC_RETRANSFER_MIN 3
`define TSRC_EXERCISE_MIN 5
`define TSRC_DEF_COOLDOWN 4'h5
`define TSRC_DEF_START 4'h3
`define TSRC_DEF_TRANSFER 4'h3
`define TSRC_DEF_RETRANSFER 4'h2
`define TSRC_DEF_EXERCISE 4'h4
`endif

// ===== rtl/tsrc_pkg.sv
// tsrc_pkg.sv: types for the transfer switch reset and option control.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tsrc_pkg;
  typedef logic [3:0] tsrc_sel_t;
  typedef logic [11:0] tsrc_secs_t;
  typedef enum logic [2:0] {
    TSRC_IDLE = 3'b001,
    TSRC_ARMED = 3'b010,
    TSRC_RUN = 3'b100
  } tsrc_test_e;
endpackage
`default_nettype wire

// ===== rtl/tsrc_sync_db.sv
// tsrc_sync_db.sv: two-flop synchroniser and debouncer for a contact.
// assumes the contact level is slow compared with the clock.
`default_nettype none
module tsrc_sync_db #(
  parameter int DB_CYC = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // contact
  input wire logic raw_in,
  output logic clean_out
);
  logic meta_reg;
  logic sync_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic differs;
  logic settled;
  assign differs = sync_reg != clean_out;
  assign settled = cnt_reg == 16'(DB_CYC);
  assign cnt_next = differs ? cnt_reg + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      clean_out <= 1'b0;
    end
    else
    begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      cnt_reg <= settled ? 16'h0000 : cnt_next;
      if (settled)
        clean_out <= sync_reg;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tsrc_ctrl.sv
// tsrc_ctrl.sv: pushbutton reset gestures and accessory option control.
// assumes buttons already debounced by the panel, other inputs but the remote test contact synchronous.
// Functional notes
// - both buttons held three seconds clear latched faults and warnings
// - warnings clear on source change or a transfer command
// - common fault output closed from fault latch until reset clear
// - both buttons held six seconds restore power-up control state
// - full reset erases the exercise schedule
// - both buttons pressed silence the sounding horn
// - horn sounds on any fault until cleared or silenced
// - selector position zero reads as ten
// - cooldown in minutes, start and transfer delays in seconds
// - retransfer three minutes per step, exercise five minutes per step
// - default selector positions give the fixed factory delays
// - gen-supplying-load closed in emergency with generator available
// - interval switch picks one or two week exercise period
// - interval change takes effect after the next exercise or when the exerciser is programmed
// - remote test input controls a loaded test
// - hold mode: test runs while contact closed, stops when open
// - momentary mode: release after one second toggles the test
// - horn enable gates the horn, off stops it on the next clock
`default_nettype none
`include "tsrc_map.svh"
module tsrc_ctrl #(
  parameter int TICK_CYC = `TSRC_TICK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // panel pushbuttons, debounced, high when pressed
  input wire logic btn_test_in,
  input wire logic btn_exercise_in,
  // fault and warning events from the transfer logic, one-cycle pulses
  input wire logic fault_event_in,
  input wire logic warn_event_in,
  input wire logic src_change_in,
  input wire logic xfer_cmd_in,
  // switch state
  input wire logic in_emergency_in,
  input wire logic gen_avail_in,
  // exerciser
  input wire logic exer_program_in,
  input wire logic exer_done_in,
  // accessory board
  input wire logic board_present_in,
  input wire tsrc_pkg::tsrc_sel_t sel_cooldown_in,
  input wire tsrc_pkg::tsrc_sel_t sel_start_in,
  input wire tsrc_pkg::tsrc_sel_t sel_transfer_in,
  input wire tsrc_pkg::tsrc_sel_t sel_retransfer_in,
  input wire tsrc_pkg::tsrc_sel_t sel_exercise_in,
  input wire logic dip_two_week_in,
  input wire logic spare_option_a_in,
  input wire logic remote_test_hold_mode_in,
  input wire logic spare_option_b_in,
  input wire logic dip_alarm_en_in,
  input wire logic remote_test_in,
  // status and control outputs
  output logic fault_latched_out,
  output logic warn_latched_out,
  output logic common_fault_out,
  output logic horn_out,
  output logic ack_flash_out,
  output logic ctrl_reset_out,
  output logic gen_load_out,
  output logic test_active_out,
  output logic gen_stop_out,
  output logic exer_set_out,
  output logic exer_two_week_out,
  output tsrc_pkg::tsrc_secs_t cooldown_s_out,
  output tsrc_pkg::tsrc_secs_t start_s_out,
  output tsrc_pkg::tsrc_secs_t transfer_s_out,
  output tsrc_pkg::tsrc_secs_t retransfer_s_out,
  output tsrc_pkg::tsrc_secs_t exercise_s_out
);
  import tsrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // one-second tick
  logic [23:0] div_reg;
  logic tick;
  assign tick = div_reg == 24'(TICK_CYC - 1);
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      div_reg <= 24'h000000;
    else
      div_reg <= tick ? 24'h000000 : div_reg + 24'h000001;
  end
  ////////////////////////////////////////////////////////////////////////
  // both-buttons hold counter
  logic both, both_d_reg, clear_fire, reset_fire;
  logic [2:0] hold_reg;
  assign both = btn_test_in & btn_exercise_in;
  // clear at three, reset at six, release cancels
  assign clear_fire = both & tick & (hold_reg == 3'(`TSRC_CLEAR_HOLD_S - 1));
  assign reset_fire = both & tick & (hold_reg == 3'(`TSRC_RESET_HOLD_S - 1));
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      hold_reg <= 3'h0;
    else if (!both)
      hold_reg <= 3'h0;
    else if (tick && hold_reg != 3'(`TSRC_RESET_HOLD_S))
      hold_reg <= hold_reg + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  // fault, warning, horn
  logic warn_clear, horn_next, silence;
  logic [2:0] ack_reg;
  assign warn_clear = src_change_in | xfer_cmd_in | clear_fire | reset_fire;
  // press of both buttons silences the horn
  assign silence = board_present_in & both & ~both_d_reg;
  // horn follows latched fault unless silenced
  assign horn_next = (fault_event_in | (horn_out & fault_latched_out))
    & ~silence & ~clear_fire & ~reset_fire
    & board_present_in & dip_alarm_en_in;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      both_d_reg <= 1'b0;
      fault_latched_out <= 1'b0;
      warn_latched_out <= 1'b0;
      common_fault_out <= 1'b0;
      horn_out <= 1'b0;
      ack_reg <= 3'h0;
      ack_flash_out <= 1'b0;
      ctrl_reset_out <= 1'b0;
    end
    else
    begin
      both_d_reg <= both;
      // common fault contact follows the latch
      if (fault_event_in)
      begin
        fault_latched_out <= 1'b1;
        common_fault_out <= 1'b1;
      end
      else if (clear_fire || reset_fire)
      begin
        fault_latched_out <= 1'b0;
        common_fault_out <= 1'b0;
      end
      if (warn_event_in)
        warn_latched_out <= 1'b1;
      else if (warn_clear)
        warn_latched_out <= 1'b0;
      horn_out <= horn_next;
      // acknowledge flash for two seconds
      if (clear_fire)
        ack_reg <= 3'h2;
      else if (tick && ack_reg != 3'h0)
        ack_reg <= ack_reg - 3'h1;
      ack_flash_out <= clear_fire | (ack_reg != 3'h0);
      // full reset pulse to the controller
      ctrl_reset_out <= reset_fire;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // delay selectors
  // spare_option_a_in and spare_option_b_in are read nowhere
  function automatic tsrc_secs_t sel_val(input tsrc_sel_t s);
    // position zero reads as ten, out of range reads as ten
    sel_val = (s == 4'h0 || s > 4'hA) ? 12'h00A : {8'h00, s};
  endfunction
  tsrc_sel_t cd_s, st_s, tr_s, rt_s, ex_s;
  assign cd_s = board_present_in ? sel_cooldown_in : `TSRC_DEF_COOLDOWN;
  assign st_s = board_present_in ? sel_start_in : `TSRC_DEF_START;
  assign tr_s = board_present_in ? sel_transfer_in : `TSRC_DEF_TRANSFER;
  assign rt_s = board_present_in ? sel_retransfer_in : `TSRC_DEF_RETRANSFER;
  assign ex_s = board_present_in ? sel_exercise_in : `TSRC_DEF_EXERCISE;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cooldown_s_out <= 12'h000;
      start_s_out <= 12'h000;
      transfer_s_out <= 12'h000;
      retransfer_s_out <= 12'h000;
      exercise_s_out <= 12'h000;
    end
    else
    begin
      cooldown_s_out <= 12'(sel_val(cd_s) * `TSRC_SEC_PER_MIN);
      start_s_out <= sel_val(st_s);
      transfer_s_out <= sel_val(tr_s);
      retransfer_s_out <= 12'(sel_val(rt_s)
        * (`TSRC_RETRANSFER_MIN * `TSRC_SEC_PER_MIN));
      exercise_s_out <= 12'(sel_val(ex_s)
        * (`TSRC_EXERCISE_MIN * `TSRC_SEC_PER_MIN));
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // exerciser schedule and gen-load output
  logic pend_reg;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      exer_set_out <= 1'b0;
      exer_two_week_out <= 1'b0;
      pend_reg <= 1'b0;
      gen_load_out <= 1'b0;
    end
    else
    begin
      gen_load_out <= in_emergency_in & gen_avail_in;
      if (reset_fire)
      begin
        exer_set_out <= 1'b0;
        pend_reg <= 1'b0;
      end
      else if (exer_program_in)
      begin
        exer_set_out <= 1'b1;
        exer_two_week_out <= board_present_in & dip_two_week_in;
        pend_reg <= 1'b0;
      end
      // new interval after the next exercise, as well as on programming above
      else if (exer_set_out && exer_done_in)
        exer_two_week_out <= board_present_in & dip_two_week_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // remote test
  logic rt_clean, rt_d_reg, press_ok, rt_fall;
  logic [1:0] press_reg;
  tsrc_test_e tst_reg, tst_next;
  tsrc_sync_db #(
    .DB_CYC(`TSRC_DEBOUNCE_CYC)
  ) u_rt_db (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .raw_in(remote_test_in & board_present_in),
    .clean_out(rt_clean)
  );
  assign rt_fall = rt_d_reg & ~rt_clean;
  // momentary-mode closures that span no one-second tick are ignored
  assign press_ok = press_reg >= 2'(`TSRC_TEST_PRESS_S);
  always_comb
  begin
    tst_next = tst_reg;
    case (tst_reg)
      TSRC_IDLE:
        if (remote_test_hold_mode_in)
          tst_next = rt_clean ? TSRC_RUN : TSRC_IDLE;
        else if (rt_fall && press_ok)
          tst_next = TSRC_RUN;
      TSRC_RUN:
        if (remote_test_hold_mode_in)
          tst_next = rt_clean ? TSRC_RUN : TSRC_IDLE;
        else if (rt_fall && press_ok)
          tst_next = TSRC_IDLE;
      default:
        tst_next = TSRC_IDLE;
    endcase
  end
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rt_d_reg <= 1'b0;
      press_reg <= 2'h0;
      tst_reg <= TSRC_IDLE;
      test_active_out <= 1'b0;
      gen_stop_out <= 1'b0;
    end
    else
    begin
      rt_d_reg <= rt_clean;
      if (!rt_clean)
        press_reg <= 2'h0;
      else if (tick && !press_ok)
        press_reg <= press_reg + 2'h1;
      tst_reg <= reset_fire ? TSRC_IDLE : tst_next;
      test_active_out <= ~reset_fire & (tst_next == TSRC_RUN);
      gen_stop_out <= (tst_reg == TSRC_RUN) & (tst_next == TSRC_IDLE);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_clk @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_held3;
    both & tick & (hold_reg == 3'h2);
  endsequence
  chk_clear_fault: assert property (
    s_held3 ##0 !fault_event_in |=> !fault_latched_out && ack_flash_out)
    else $error("three second hold did not clear the fault");
  chk_warn_auto: assert property (
    (src_change_in | xfer_cmd_in) & ~warn_event_in |=> !warn_latched_out)
    else $error("warning not cleared automatically");
  chk_common_fault: assert property (
    common_fault_out == fault_latched_out)
    else $error("common fault differs from latch");
  chk_full_reset: assert property (
    both & tick & (hold_reg == 3'h5) |=> ctrl_reset_out && !exer_set_out)
    else $error("six second hold did not reset");
  chk_horn_silence: assert property (
    silence |=> !horn_out)
    else $error("horn not silenced");
  chk_horn_gate: assert property (
    !dip_alarm_en_in |=> !horn_out)
    else $error("horn sounds while disabled");
  chk_gen_load: assert property (
    ##1 gen_load_out == $past(in_emergency_in & gen_avail_in))
    else $error("gen load output wrong");
  chk_hold_stop: assert property (
    remote_test_hold_mode_in & !rt_clean & (tst_reg == TSRC_RUN)
    |=> gen_stop_out && !test_active_out)
    else $error("maintained test did not stop");
  chk_short_press: assert property (
    !remote_test_hold_mode_in & rt_fall & !press_ok & (tst_reg == TSRC_IDLE)
    |=> tst_reg == TSRC_IDLE)
    else $error("short press started a test");
endmodule
`default_nettype wire

// ===== sim/tsrc_operator.sv
// tsrc_operator.sv: operator at both pushbuttons and the remote test contact.
// assumes the bench raises its requests at the falling clock edge.
`default_nettype none
module tsrc_operator #(
  parameter int MIN_CLOSE_CYC = 60
) (
  // clock
  input wire logic clk_in,
  // requests from the bench
  input wire logic both_req_in,
  input wire logic remote_req_in,
  // contacts seen by the controller
  output var logic btn_test_out,
  output var logic btn_exercise_out,
  output var logic remote_test_out
);
  logic both_seen = 1'b0;
  logic remote_seen = 1'b0;
  int unsigned closed_cyc;
  initial
  begin
    btn_test_out = 1'b0;
    btn_exercise_out = 1'b0;
    remote_test_out = 1'b0;
    closed_cyc = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // requests taken at the rising edge, clear of the bench's falling edge
  always @(posedge clk_in)
  begin
    both_seen <= both_req_in;
    remote_seen <= remote_req_in;
  end
  always @(negedge clk_in)
  begin
    btn_test_out <= both_seen;
    btn_exercise_out <= both_seen;
    // contact kept closed at least one second
    if (remote_test_out === 1'b1 && closed_cyc < MIN_CLOSE_CYC)
    begin
      closed_cyc <= closed_cyc + 1;
    end
    else
    begin
      remote_test_out <= remote_seen;
      closed_cyc <= remote_seen ? closed_cyc + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tsrc_ctrl_tb.sv
// tsrc_ctrl_tb.sv: self-checking bench for the reset and option control.
// assumes a shortened one-second tick of TICK clock cycles.
`default_nettype none
module tsrc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tsrc_pkg::*;
  localparam int TICK = 20;
  localparam int LIMIT = 8000;
  logic clk_in = 1'b0;
  logic resetn_in, both_req, remote_req;
  logic btn_test_in, btn_exercise_in, remote_test_in;
  logic fault_event_in, warn_event_in, src_change_in, xfer_cmd_in;
  logic in_emergency_in, gen_avail_in, exer_program_in, exer_done_in;
  logic board_present_in, dip_two_week_in, spare_option_a_in;
  logic remote_test_hold_mode_in, spare_option_b_in, dip_alarm_en_in;
  tsrc_sel_t sel_cooldown_in, sel_start_in, sel_transfer_in;
  tsrc_sel_t sel_retransfer_in, sel_exercise_in;
  logic fault_latched_out, warn_latched_out, common_fault_out, horn_out;
  logic ack_flash_out, ctrl_reset_out, gen_load_out, test_active_out;
  logic gen_stop_out, exer_set_out, exer_two_week_out;
  tsrc_secs_t cooldown_s_out, start_s_out, transfer_s_out;
  tsrc_secs_t retransfer_s_out, exercise_s_out;
  int fails, num_checks, cyc, resets, stops;

  tsrc_ctrl #(.TICK_CYC(TICK)) uut (
    .clk_in, .resetn_in, .btn_test_in, .btn_exercise_in, .fault_event_in,
    .warn_event_in, .src_change_in, .xfer_cmd_in, .in_emergency_in,
    .gen_avail_in, .exer_program_in, .exer_done_in, .board_present_in,
    .sel_cooldown_in, .sel_start_in, .sel_transfer_in, .sel_retransfer_in,
    .sel_exercise_in, .dip_two_week_in, .spare_option_a_in,
    .remote_test_hold_mode_in, .spare_option_b_in, .dip_alarm_en_in,
    .remote_test_in, .fault_latched_out, .warn_latched_out,
    .common_fault_out, .horn_out, .ack_flash_out, .ctrl_reset_out,
    .gen_load_out, .test_active_out, .gen_stop_out, .exer_set_out,
    .exer_two_week_out, .cooldown_s_out, .start_s_out, .transfer_s_out,
    .retransfer_s_out, .exercise_s_out
  );
  tsrc_operator #(.MIN_CLOSE_CYC(2 * TICK + 20)) far (
    .clk_in, .both_req_in(both_req), .remote_req_in(remote_req),
    .btn_test_out(btn_test_in), .btn_exercise_out(btn_exercise_in),
    .remote_test_out(remote_test_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_secs(input string name, input tsrc_secs_t exp,
                          input tsrc_secs_t got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  function automatic tsrc_secs_t exp_secs(input tsrc_sel_t sel,
                                          input int mult);
    int pos;
    pos = (sel == 4'h0 || sel > 4'hA) ? 10 : int'(sel);
    return tsrc_secs_t'(pos * mult);
  endfunction
  task automatic chk_delays(input tsrc_sel_t c, s, t, r, e);
    chk_secs("cooldown", exp_secs(c, 60), cooldown_s_out);
    chk_secs("start", exp_secs(s, 1), start_s_out);
    chk_secs("transfer", exp_secs(t, 1), transfer_s_out);
    chk_secs("retransfer", exp_secs(r, 180), retransfer_s_out);
    chk_secs("exercise", exp_secs(e, 300), exercise_s_out);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    cycles(1);
    sig = 1'b0;
    cycles(2);
  endtask
  task automatic hold_both(input int n);
    both_req = 1'b1;
    cycles(n);
    both_req = 1'b0;
    cycles(3);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // counted mid-cycle, where the registered outputs have settled
  always @(negedge clk_in)
  begin
    cyc++;
    if (ctrl_reset_out === 1'b1)
      resets++;
    if (gen_stop_out === 1'b1)
      stops++;
    if (cyc == LIMIT)
    begin
      fails++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {both_req, remote_req, fault_event_in, warn_event_in} = 4'h0;
    {src_change_in, xfer_cmd_in, in_emergency_in, gen_avail_in} = 4'h0;
    {exer_program_in, exer_done_in, board_present_in} = 3'h0;
    {dip_two_week_in, spare_option_a_in, spare_option_b_in} = 3'h0;
    {remote_test_hold_mode_in, dip_alarm_en_in} = 2'h0;
    {sel_cooldown_in, sel_start_in, sel_transfer_in} = 12'h777;
    {sel_retransfer_in, sel_exercise_in} = 8'h77;
    {fails, num_checks, cyc, resets, stops} = '0;
    resetn_in = 1'b0;
    void'($urandom(32'hBBDD));
    cycles(4);
    chk_bit("fault_in_reset", 1'b0, fault_latched_out);
    resetn_in = 1'b1;
    cycles(3);
    chk_delays(4'h5, 4'h3, 4'h3, 4'h2, 4'h4);
    board_present_in = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      {sel_cooldown_in, sel_start_in, sel_transfer_in} = 12'($urandom);
      {sel_retransfer_in, sel_exercise_in} = 8'($urandom);
      if (i < 2)
        {sel_cooldown_in, sel_start_in, sel_transfer_in, sel_retransfer_in,
         sel_exercise_in} = (i == 0) ? 20'h0 : 20'hAAAAA;
      {spare_option_a_in, spare_option_b_in} = 2'($urandom);
      cycles(3);
      chk_delays(sel_cooldown_in, sel_start_in, sel_transfer_in,
                 sel_retransfer_in, sel_exercise_in);
    end
    for (int i = 0; i < 4; i++)
    begin
      {in_emergency_in, gen_avail_in} = 2'(i);
      cycles(3);
      chk_bit("gen_load", 1'(i == 3), gen_load_out);
    end
    dip_alarm_en_in = 1'b1;
    pulse(fault_event_in);
    chk_bit("common_fault", 1'b1, common_fault_out);
    chk_bit("horn", 1'b1, horn_out);
    hold_both(TICK + 5);
    chk_bit("horn_silence", 1'b0, horn_out);
    hold_both(TICK + 5);
    chk_bit("fault_early", 1'b1, fault_latched_out);
    hold_both(3 * TICK + 5);
    chk_bit("fault_clear", 1'b0, fault_latched_out);
    chk_bit("common_clear", 1'b0, common_fault_out);
    chk_bit("ack_flash", 1'b1, ack_flash_out);
    chk_bit("no_reset", 1'b1, 1'(resets == 0));
    pulse(fault_event_in);
    chk_bit("horn_again", 1'b1, horn_out);
    dip_alarm_en_in = 1'b0;
    cycles(3);
    chk_bit("horn_off", 1'b0, horn_out);
    dip_alarm_en_in = 1'b1;
    pulse(warn_event_in);
    chk_bit("warn_set", 1'b1, warn_latched_out);
    pulse(src_change_in);
    chk_bit("warn_src", 1'b0, warn_latched_out);
    pulse(warn_event_in);
    pulse(xfer_cmd_in);
    chk_bit("warn_xfer", 1'b0, warn_latched_out);
    dip_two_week_in = 1'b1;
    pulse(exer_program_in);
    chk_bit("exer_set", 1'b1, exer_set_out);
    chk_bit("two_week", 1'b1, exer_two_week_out);
    dip_two_week_in = 1'b0;
    cycles(3);
    chk_bit("two_week_kept", 1'b1, exer_two_week_out);
    pulse(exer_done_in);
    chk_bit("one_week", 1'b0, exer_two_week_out);
    pulse(warn_event_in);
    hold_both(6 * TICK + 5);
    chk_bit("ctrl_reset", 1'b1, 1'(resets == 1));
    chk_bit("exer_erased", 1'b0, exer_set_out);
    chk_bit("fault_reset", 1'b0, fault_latched_out);
    chk_bit("warn_reset", 1'b0, warn_latched_out);
    for (int k = 0; k < 2; k++)
    begin
      remote_req = 1'b1;
      cycles(3 * TICK);
      remote_req = 1'b0;
      cycles(40);
      chk_bit("test_moment", 1'(k == 0), test_active_out);
    end
    chk_bit("stop_moment", 1'b1, 1'(stops == 1));
    remote_test_hold_mode_in = 1'b1;
    remote_req = 1'b1;
    cycles(3 * TICK);
    chk_bit("test_hold", 1'b1, test_active_out);
    remote_req = 1'b0;
    cycles(40);
    chk_bit("test_end", 1'b0, test_active_out);
    chk_bit("stop_hold", 1'b1, 1'(stops == 2));
    give_verdict();
  end
endmodule
`default_nettype wire
